// ---- design/clw_map.vh ----
// Register map, field layout and timing constants for the comm-loss
// watchdog. Assumes 32-bit APB data and a 250 MHz system clock.
`ifndef CLW_MAP_VH
`define CLW_MAP_VH

// Register byte offsets
`define CLW_CTRL_OFS      12'h000
`define CLW_INTERVAL_OFS  12'h004
`define CLW_STATUS_OFS    12'h008
`define CLW_ERRCNT_OFS    12'h00c

// Control field positions
`define CLW_CTRL_NETMODE  0
`define CLW_CTRL_FLTCLR   1
`define CLW_CTRL_ALMSEL   4
`define CLW_ALMSEL_W      3
`define CLW_TERMINALS     7

// Status field positions
`define CLW_STAT_FAULT    0
`define CLW_STAT_ALARM    1
`define CLW_STAT_ARMED    2

// Interval in units of 0.1 s
`define CLW_INTERVAL_W    14
`define CLW_INTERVAL_OFF  14'h270f
`define CLW_INTERVAL_MAX  14'h270e
`define CLW_INTERVAL_RST  14'h270f
`define CLW_INTERVAL_NOW  14'h0000
`define CLW_INTERVAL_STEP 14'h0001

// Alarm terminal drive with every pin released
`define CLW_PINS_OFF      7'h00

// Tick period: 100 ms at 4 ns per cycle
`define CLW_TICK_MS       100
`define CLW_CLK_NS        4
`define CLW_TICK_CYCLES   ((`CLW_TICK_MS * 1000000) / `CLW_CLK_NS)

`define CLW_CNT_W         16
`endif

// ---- design/clw_tick.v ----
// Tick generator: one-cycle pulse every PERIOD cycles while run is high.
// Assumes the same clock and synchronous reset as the watchdog core.
module clw_tick #(
  parameter PERIOD = 25000000
) (
  input  wire clock,
  input  wire rst,
  input  wire run,
  output reg  tick
);
  reg [31:0] count;

  always @(posedge clock) begin
    if (rst || !run) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == PERIOD - 1) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule // clw_tick

// ---- design/clw_watchdog.v ----
// Comm-loss watchdog: error counter, alarm output, signal-loss timer
// with an APB register port. Assumes the link receiver gives one-cycle
// frame and error strobes on this clock, and that the trip stops the drive;
// the trip itself is latched here until software clears it.
`include "clw_map.vh"

// How it works
// - Count errors from zero, readable over APB
// - Counter lives in flops, reset clears it
// - Alarm output while error present, selectable
// - Signal loss raises fault and trip
// - Interval 9999 disables loss supervision
// - Interval zero faults on entering network mode
// - 0.1 to 999.8 s interval supervises master
// - Any frame restarts check counter
// - Timer idle until first frame after entry
module clw_watchdog #(
  parameter TICK_CYCLES = `CLW_TICK_CYCLES
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        frame_rx,
  input  wire        comm_error,
  output reg  [6:0]  comm_error_alarm_output,
  output reg  [6:0]  comm_error_alarm_oe,
  output reg         comm_loss_fault,
  output wire        drive_trip
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_TRIP  = 3'b100;

  reg [2:0]                  state;
  reg [2:0]                  next_state;
  reg                        net_mode;
  reg                        net_mode_d;
  reg [`CLW_ALMSEL_W-1:0]    alarm_sel;
  reg [`CLW_INTERVAL_W-1:0]  interval;
  reg [`CLW_INTERVAL_W-1:0]  elapsed;
  reg [`CLW_CNT_W-1:0]       comm_error_counter;
  reg                        alarm_level;
  wire                       tick;
  wire                       wr_en;
  wire                       rd_en;
  wire                       fault_clr;
  wire                       entering;
  wire                       lost;

  function addr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  function supervised;
    input [`CLW_INTERVAL_W-1:0] iv;
    begin
      supervised = (iv != `CLW_INTERVAL_NOW) &&
                   (iv != `CLW_INTERVAL_OFF) &&
                   (iv <= `CLW_INTERVAL_MAX);
    end
  endfunction

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  // Read data is loaded in the setup cycle, so it already stands as a
  // flop output when the zero-wait access edge takes it
  assign rd_en   = psel && !penable && !pwrite;
  // Unmapped offsets answer with an error and change nothing
  assign pslverr = psel && penable &&
                   !(addr_hit(paddr, `CLW_CTRL_OFS) ||
                     addr_hit(paddr, `CLW_INTERVAL_OFS) ||
                     addr_hit(paddr, `CLW_STATUS_OFS) ||
                     addr_hit(paddr, `CLW_ERRCNT_OFS));
  assign fault_clr = wr_en && addr_hit(paddr, `CLW_CTRL_OFS) &&
                     pwdata[`CLW_CTRL_FLTCLR];
  // Rising edge of net mode; the delayed copy resets low like the mode
  assign entering  = net_mode && !net_mode_d;
  assign drive_trip = comm_loss_fault;

  // Writes; read-only registers ignore them without error
  always @(posedge clock) begin
    if (rst) begin
      net_mode  <= 1'b0;
      alarm_sel <= {`CLW_ALMSEL_W{1'b0}};
      interval  <= `CLW_INTERVAL_RST;
    end else if (wr_en) begin
      if (addr_hit(paddr, `CLW_CTRL_OFS)) begin
        net_mode  <= pwdata[`CLW_CTRL_NETMODE];
        alarm_sel <= pwdata[`CLW_CTRL_ALMSEL +: `CLW_ALMSEL_W];
      end
      if (addr_hit(paddr, `CLW_INTERVAL_OFS))
        interval <= pwdata[`CLW_INTERVAL_W-1:0];
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      prdata <= 32'h0;
      if (addr_hit(paddr, `CLW_CTRL_OFS)) begin
        prdata[`CLW_CTRL_NETMODE] <= net_mode;
        prdata[`CLW_CTRL_ALMSEL +: `CLW_ALMSEL_W] <= alarm_sel;
      end
      if (addr_hit(paddr, `CLW_INTERVAL_OFS))
        prdata[`CLW_INTERVAL_W-1:0] <= interval;
      if (addr_hit(paddr, `CLW_STATUS_OFS)) begin
        prdata[`CLW_STAT_FAULT] <= comm_loss_fault;
        prdata[`CLW_STAT_ALARM] <= alarm_level;
        prdata[`CLW_STAT_ARMED] <= (state == ST_ARMED);
      end
      if (addr_hit(paddr, `CLW_ERRCNT_OFS))
        prdata[`CLW_CNT_W-1:0] <= comm_error_counter;
    end
  end

  always @(posedge clock) begin
    if (rst)
      comm_error_counter <= {`CLW_CNT_W{1'b0}};
    // Saturates so a long burst never reads back as a small count
    // saturating error count
    else if (comm_error && comm_error_counter != {`CLW_CNT_W{1'b1}})
      comm_error_counter <= comm_error_counter + {{`CLW_CNT_W-1{1'b0}}, 1'b1};
  end

  always @(posedge clock) begin
    if (rst) begin
      alarm_level             <= 1'b0;
      comm_error_alarm_output <= `CLW_PINS_OFF;
      comm_error_alarm_oe     <= `CLW_PINS_OFF;
    end else begin
      alarm_level <= comm_error;
      // Open collector: pull low only on the selected terminal
      comm_error_alarm_output <= `CLW_PINS_OFF;
      comm_error_alarm_oe     <= `CLW_PINS_OFF;
      // A selection past the last terminal leaves every pin released
      if (alarm_sel < `CLW_TERMINALS)
        comm_error_alarm_oe[alarm_sel] <= comm_error;
    end
  end

  // A frame also clears the prescaler, so the first tick after it is a
  // full 0.1 s away; otherwise a loss could be declared up to one tick
  // early
  clw_tick #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .clock (clock),
    .rst   (rst || frame_rx),
    .run   (state == ST_ARMED),
    .tick  (tick)
  );

  assign lost = tick && (elapsed + `CLW_INTERVAL_STEP >= interval);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (entering && interval == `CLW_INTERVAL_NOW)
          next_state = ST_TRIP;
        else if (net_mode && frame_rx && supervised(interval))
          next_state = ST_ARMED;
      end
      ST_ARMED: begin
        // Leaving network mode drops supervision until a new first frame
        if (!net_mode)
          next_state = ST_IDLE;
        else if (lost && !frame_rx)
          next_state = ST_TRIP;
      end
      ST_TRIP: begin
        // Only a clear releases the trip; leaving network mode does not,
        // so the drive stays stopped until software acknowledges it
        if (fault_clr)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state           <= ST_IDLE;
      net_mode_d      <= 1'b0;
      elapsed         <= {`CLW_INTERVAL_W{1'b0}};
      comm_loss_fault <= 1'b0;
    end else begin
      state      <= next_state;
      net_mode_d <= net_mode;
      if (frame_rx || state != ST_ARMED)
        elapsed <= {`CLW_INTERVAL_W{1'b0}};
      else if (tick)
        elapsed <= elapsed + `CLW_INTERVAL_STEP;
      // Taken from next_state so fault and state move on one edge
      // latch fault until cleared
      comm_loss_fault <= (next_state == ST_TRIP);
    end
  end
endmodule // clw_watchdog

// ---- verif/clw_master.sv ----
// Serial-link master model giving frame and error strobes.
// Assumes the watchdog clock; each strobe lasts one cycle.
module clw_master (
  input wire logic clock,
  output logic     frame_rx,
  output logic     comm_error
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_rx = 1'b0;
    comm_error = 1'b0;
  end
  task automatic frame();
    @(posedge clock) frame_rx <= 1'b1;
    @(posedge clock) frame_rx <= 1'b0;
  endtask
  task automatic err();
    @(posedge clock) comm_error <= 1'b1;
    @(posedge clock) comm_error <= 1'b0;
  endtask
endmodule // clw_master

// ---- verif/clw_sva.sv ----
// Port checker for the comm-loss watchdog.
// Assumes one clock domain and the synchronous active-high reset.
module clw_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comm_error,
  input wire logic [6:0]  comm_error_alarm_output,
  input wire logic [6:0]  comm_error_alarm_oe,
  input wire logic        comm_loss_fault,
  input wire logic        drive_trip
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_ready_always:
    assert property (pready) else $error("pready low");
  chk_slverr_map:
    assert property (psel && penable |-> pslverr == !(paddr == 12'h000
      || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00c))
      else $error("pslverr wrong");
  chk_trip_follows:
    assert property (drive_trip == comm_loss_fault)
      else $error("trip differs from fault");
  chk_alarm_pulls_low:
    assert property (comm_error_alarm_output == 7'h00)
      else $error("alarm output driven high");
  chk_alarm_idle:
    assert property (!comm_error |=> comm_error_alarm_oe == 7'h00)
      else $error("alarm without error");
  chk_alarm_one_pin:
    assert property ($onehot0(comm_error_alarm_oe))
      else $error("alarm on several pins");
  chk_fault_latched:
    assert property (comm_loss_fault && !(psel && penable && pwrite
      && paddr == 12'h000 && pwdata[1]) |=> comm_loss_fault)
      else $error("fault dropped");
  chk_reset_clears:
    assert property ($fell(rst) |-> !comm_loss_fault
      && comm_error_alarm_oe == 7'h00) else $error("reset left state");
endmodule // clw_sva
bind clw_watchdog clw_sva u_chk (
  .clock                   (clock),
  .rst                     (rst),
  .psel                    (psel),
  .penable                 (penable),
  .pwrite                  (pwrite),
  .paddr                   (paddr),
  .pwdata                  (pwdata),
  .pready                  (pready),
  .pslverr                 (pslverr),
  .comm_error              (comm_error),
  .comm_error_alarm_output (comm_error_alarm_output),
  .comm_error_alarm_oe     (comm_error_alarm_oe),
  .comm_loss_fault         (comm_loss_fault),
  .drive_trip              (drive_trip)
);

// ---- verif/clw_tb.sv ----
// Self-checking bench: APB register access plus a link master.
// Assumes TICK_CYCLES of 10, so one 0.1 s step is 10 clocks.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, se;
  logic        frame_rx, comm_error, comm_loss_fault, drive_trip;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  alm, alm_oe;
  int          fails, samples_checked, cyc;
  clw_watchdog #(.TICK_CYCLES(10)) dut (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_rx(frame_rx), .comm_error(comm_error),
    .comm_error_alarm_output(alm), .comm_error_alarm_oe(alm_oe),
    .comm_loss_fault(comm_loss_fault), .drive_trip(drive_trip));
  clw_master m (.clock(clock), .frame_rx(frame_rx),
    .comm_error(comm_error));
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock);
    while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize();
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // A hang ends the run as a failure
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    xfer(0, 12'h00c, 0);
    chk("errcnt", r, 32'h0);
    xfer(0, 12'h004, 0);
    chk("interval", r, 32'h270f);
    xfer(1, 12'h000, 32'h20);
    m.err();
    #1 chk("alarm oe", alm_oe, 32'h4);
    chk("alarm out", alm, 32'h0);
    m.err();
    m.err();
    xfer(1, 12'h00c, 32'h0);
    xfer(0, 12'h00c, 0);
    chk("errcnt", r, 32'h3);
    xfer(0, 12'h010, 0);
    chk("slverr", se, 32'h1);
    xfer(1, 12'h000, 32'h21);
    m.frame();
    repeat (200) @(posedge clock);
    chk("no check", comm_loss_fault, 32'h0);
    xfer(1, 12'h004, 32'h5);
    repeat (80) @(posedge clock);
    chk("idle", comm_loss_fault, 32'h0);
    m.frame();
    xfer(0, 12'h008, 0);
    chk("armed", r, 32'h4);
    repeat (27) @(posedge clock);
    m.frame();
    repeat (35) @(posedge clock);
    chk("restart", comm_loss_fault, 32'h0);
    repeat (25) @(posedge clock);
    chk("loss", drive_trip, 32'h1);
    xfer(0, 12'h008, 0);
    chk("status", r[0], 32'h1);
    xfer(1, 12'h000, 32'h23);
    #1 chk("cleared", comm_loss_fault, 32'h0);
    xfer(1, 12'h000, 32'h20);
    xfer(1, 12'h004, 32'h0);
    xfer(1, 12'h000, 32'h21);
    repeat (3) @(posedge clock);
    chk("zero", comm_loss_fault, 32'h1);
    // Mid-run reset must drop the trip and the error count
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    xfer(0, 12'h00c, 0);
    chk("errcnt reset", r, 32'h0);
    chk("fault reset", comm_loss_fault, 32'h0);
    xfer(1, 12'h004, 32'h270e);
    xfer(1, 12'h000, 32'h1);
    m.frame();
    xfer(0, 12'h008, 0);
    chk("armed 999.8", r, 32'h4);
    xfer(1, 12'h000, 32'h0);
    xfer(0, 12'h008, 0);
    chk("disarmed", r, 32'h0);
    summarize();
  end
endmodule // testbench
